// ===== core/vf_ramp_pkg.sv
package vf_ramp_pkg;
  localparam int FW = 17;
  localparam int VW = 13;
  localparam int TW = 16;
  localparam int AW = 8;
  localparam int NT = 8;
  localparam int DIVW = FW + VW;

  // Byte offsets of the register map
  localparam logic [AW-1:0] OFS_LOCK   = 8'h00;
  localparam logic [AW-1:0] OFS_MAXF   = 8'h04;
  localparam logic [AW-1:0] OFS_MIDF   = 8'h08;
  localparam logic [AW-1:0] OFS_MINF   = 8'h0C;
  localparam logic [AW-1:0] OFS_MAXV   = 8'h10;
  localparam logic [AW-1:0] OFS_MIDV   = 8'h14;
  localparam logic [AW-1:0] OFS_BOOST  = 8'h18;
  localparam logic [AW-1:0] OFS_LOWLIM = 8'h1C;
  localparam logic [AW-1:0] OFS_SCHEME = 8'h20;
  localparam logic [AW-1:0] OFS_RESTOR = 8'h24;
  localparam logic [AW-1:0] OFS_RAMP0  = 8'h28;
  localparam logic [AW-1:0] OFS_EMERG  = 8'h48;
  localparam logic [AW-1:0] OFS_REVEN  = 8'h4C;
  localparam logic [AW-1:0] OFS_CTRL   = 8'h50;
  localparam logic [AW-1:0] OFS_TARGET = 8'h54;
  localparam logic [AW-1:0] OFS_FREQ   = 8'h58;
  localparam logic [AW-1:0] OFS_VOLT   = 8'h5C;

  // Factory values; frequency in 0.01 Hz, voltage in 0.1 V, time in 0.1 s
  localparam logic [FW-1:0] DEF_MAXF   = 17'h01388;
  localparam logic [FW-1:0] DEF_MIDF   = 17'h001F4;
  localparam logic [FW-1:0] DEF_MINF   = 17'h00032;
  localparam logic [VW-1:0] DEF_MAXV   = 13'h0ED8;
  localparam logic [VW-1:0] DEF_MIDV   = 13'h00C8;
  localparam logic [VW-1:0] DEF_BOOST  = 13'h0064;
  localparam logic [FW-1:0] DEF_LOWLIM = 17'h00000;
  localparam logic [TW-1:0] DEF_RAMP   = 16'h0064;
  localparam logic [TW-1:0] DEF_EMERG  = 16'h0000;
  localparam logic [7:0]    DEF_RESTOR = 8'h00;

  // Limits of the settings
  localparam logic [FW-1:0] MAXF_LO    = 17'h003E8;
  localparam logic [FW-1:0] MAXF_HI    = 17'h186A0;
  localparam logic [VW-1:0] BOOST_HI   = 13'h0ED8;
  localparam logic [VW-1:0] VOLT_HI    = 13'h13EC;
  localparam logic [7:0]    RESTOR_HI  = 8'h0A;
  localparam logic [7:0]    RESTOR_CMD = 8'h08;
  localparam logic [1:0]    JOG_SET    = 2'h3;

  localparam int CLK_NS   = 40;
  localparam int TENTH_NS = 100000000;

  typedef struct packed {
    logic                  lock;
    logic [FW-1:0]         maxF;
    logic [FW-1:0]         midF;
    logic [FW-1:0]         minF;
    logic [VW-1:0]         maxV;
    logic [VW-1:0]         midV;
    logic [VW-1:0]         boost;
    logic [FW-1:0]         lowLim;
    logic                  scheme;
    logic [7:0]            restore;
    logic [NT-1:0][TW-1:0] rampT;
    logic [TW-1:0]         emergT;
    logic                  revEn;
  } cfg_t;

  localparam cfg_t CFG_DEFAULT = '{
    lock: 1'b0, maxF: DEF_MAXF, midF: DEF_MIDF, minF: DEF_MINF,
    maxV: DEF_MAXV, midV: DEF_MIDV, boost: DEF_BOOST,
    lowLim: DEF_LOWLIM, scheme: 1'b0, restore: DEF_RESTOR,
    rampT: {NT{DEF_RAMP}}, emergT: DEF_EMERG, revEn: 1'b1};

  typedef struct packed {
    logic       run;
    logic       dir;
    logic       jog;
    logic       segMode;
    logic [1:0] seg;
  } ctrl_t;

  typedef struct packed {
    logic       estop;
    logic [1:0] accelSel;
  } terminals_t;

  typedef struct packed {
    logic [FW-1:0] freq;
    logic [VW-1:0] volt;
    logic          outEn;
    logic          reverse;
  } drive_t;

  typedef enum logic {
    DIV_IDLE = 1'b0,
    DIV_RUN  = 1'b1
  } div_state_t;

  typedef struct packed {
    terminals_t    syncA;
    terminals_t    syncB;
    cfg_t          cfg;
    ctrl_t         ctrl;
    logic [FW-1:0] target;
    logic          estopHeld;
    logic [39:0]   acc;
    drive_t        drv;
    div_state_t    dst;
    logic [DIVW-1:0] num;
    logic [FW-1:0] den;
    logic [DIVW-1:0] quo;
    logic [FW:0]   rem;
    logic [4:0]    divCnt;
    logic [VW-1:0] base;
    logic          pready;
    logic          pslverr;
    logic [31:0]   prdata;
  } state_t;
endpackage : vf_ramp_pkg

// ===== core/vf_curve_and_ramp_control.sv
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module vf_curve_and_ramp_control #(
  parameter int TENTH_CYCLES = vf_ramp_pkg::TENTH_NS / vf_ramp_pkg::CLK_NS
) (
  input  wire logic                   mclk,
  input  wire logic                   rst_n,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic                        pready,
  output logic [31:0]                 prdata,
  output logic                        pslverr,
  input  wire vf_ramp_pkg::terminals_t terminals,
  output vf_ramp_pkg::drive_t         drive
);
  import vf_ramp_pkg::*;

  if (TENTH_CYCLES < 1 || TENTH_CYCLES >= (1 << 24)) begin : g_chk
    $error("TENTH_CYCLES out of range");
  end

  localparam logic [23:0] TENTH = 24'(TENTH_CYCLES);

  state_t s_ff;
  state_t nxt_s;

  function automatic logic [FW-1:0] fMin(input logic [FW-1:0] a,
                                         input logic [FW-1:0] b);
    fMin = (a < b) ? a : b;
  endfunction : fMin

  function automatic logic [VW-1:0] vMin(input logic [VW-1:0] a,
                                         input logic [VW-1:0] b);
    vMin = (a < b) ? a : b;
  endfunction : vMin

  // A zero time would make the span zero and step every cycle, so it counts as one 0.1 s unit
  function automatic logic [39:0] timeCycles(input logic [TW-1:0] t);
    logic [TW-1:0] tt;
    tt = (t == '0) ? TW'(1) : t;
    timeCycles = 40'(tt) * 40'(TENTH);
  endfunction : timeCycles

  function automatic logic [31:0] readReg(input state_t s,
                                          input logic [AW-1:0] a,
                                          output logic bad);
    readReg = '0;
    bad = 1'b0;
    if (a >= OFS_RAMP0 && a < OFS_EMERG && a[1:0] == 2'b00) begin
      readReg = 32'(s.cfg.rampT[3'((a - OFS_RAMP0) >> 2)]);
    end else begin
      unique case (a)
        OFS_LOCK:   readReg = 32'(s.cfg.lock);
        OFS_MAXF:   readReg = 32'(s.cfg.maxF);
        OFS_MIDF:   readReg = 32'(s.cfg.midF);
        OFS_MINF:   readReg = 32'(s.cfg.minF);
        OFS_MAXV:   readReg = 32'(s.cfg.maxV);
        OFS_MIDV:   readReg = 32'(s.cfg.midV);
        OFS_BOOST:  readReg = 32'(s.cfg.boost);
        OFS_LOWLIM: readReg = 32'(s.cfg.lowLim);
        OFS_SCHEME: readReg = 32'(s.cfg.scheme);
        OFS_RESTOR: readReg = 32'(s.cfg.restore);
        OFS_EMERG:  readReg = 32'(s.cfg.emergT);
        OFS_REVEN:  readReg = 32'(s.cfg.revEn);
        OFS_CTRL:   readReg = 32'(s.ctrl);
        OFS_TARGET: readReg = 32'(s.target);
        OFS_FREQ:   readReg = 32'(s.drv.freq);
        OFS_VOLT:   readReg = {s.drv.outEn, s.drv.reverse,
                               s.estopHeld, 16'h0000, s.drv.volt};
        default:    bad = 1'b1;
      endcase
    end
  endfunction : readReg

  always_comb begin
    logic [VW-1:0] effMax;
    logic [VW-1:0] effBoost;
    logic [VW-1:0] effMid;
    logic [FW-1:0] lim;
    logic [FW-1:0] goal;
    logic [FW-1:0] f;
    logic [1:0]    pairSel;
    logic [TW-1:0] tActive;
    logic [39:0]   span;
    logic          running;
    logic          wantRev;
    logic          bad;
    logic [31:0]   rd;
    logic [FW:0]   r;
    nxt_s = s_ff;
    bad = 1'b0;
    rd = '0;
    r = '0;
    effMax = '0;
    effBoost = '0;
    effMid = '0;
    lim = '0;
    goal = '0;
    f = '0;
    pairSel = '0;
    tActive = '0;
    span = '0;
    running = 1'b0;
    wantRev = 1'b0;

    // Terminal pins are asynchronous to mclk
    nxt_s.syncA = terminals;
    nxt_s.syncB = s_ff.syncA;

    // APB slave: one wait state, write lands with pready high
    nxt_s.pready = 1'b0;
    if (psel && penable && !s_ff.pready) begin
      rd = readReg(s_ff, paddr, bad);
      nxt_s.pready = 1'b1;
      nxt_s.prdata = pwrite ? 32'h00000000 : rd;
      nxt_s.pslverr = bad;
    end
    if (psel && penable && s_ff.pready && pwrite && !s_ff.pslverr) begin
      if (paddr == OFS_LOCK) begin
        nxt_s.cfg.lock = pwdata[0];
      end else if (paddr == OFS_CTRL) begin
        nxt_s.ctrl = ctrl_t'(pwdata[5:0]);
      end else if (paddr == OFS_TARGET) begin
        nxt_s.target = fMin(pwdata[FW-1:0], MAXF_HI);
      end else if (!s_ff.cfg.lock) begin
        if (paddr >= OFS_RAMP0 && paddr < OFS_EMERG) begin
          nxt_s.cfg.rampT[3'((paddr - OFS_RAMP0) >> 2)] = pwdata[TW-1:0];
        end else begin
          unique case (paddr)
            OFS_MAXF:
              if (pwdata[FW-1:0] >= MAXF_LO && pwdata[FW-1:0] <= MAXF_HI
                  && pwdata[FW-1:0] > s_ff.cfg.lowLim)
                nxt_s.cfg.maxF = pwdata[FW-1:0];
            OFS_MIDF:   nxt_s.cfg.midF = fMin(pwdata[FW-1:0], MAXF_HI);
            OFS_MINF:   nxt_s.cfg.minF = fMin(pwdata[FW-1:0], MAXF_HI);
            OFS_MAXV:   nxt_s.cfg.maxV = vMin(pwdata[VW-1:0], VOLT_HI);
            OFS_MIDV:   nxt_s.cfg.midV = vMin(pwdata[VW-1:0], VOLT_HI);
            OFS_BOOST:  nxt_s.cfg.boost = vMin(pwdata[VW-1:0], BOOST_HI);
            OFS_LOWLIM:
              if (pwdata[FW-1:0] < s_ff.cfg.maxF)
                nxt_s.cfg.lowLim = pwdata[FW-1:0];
            OFS_SCHEME: nxt_s.cfg.scheme = pwdata[0];
            OFS_RESTOR:
              if (pwdata[7:0] == RESTOR_CMD) begin
                nxt_s.cfg = CFG_DEFAULT;
              end else if (pwdata[7:0] <= RESTOR_HI) begin
                nxt_s.cfg.restore = pwdata[7:0];
              end
            OFS_EMERG:  nxt_s.cfg.emergT = pwdata[TW-1:0];
            OFS_REVEN:  nxt_s.cfg.revEn = pwdata[0];
            default:    nxt_s.cfg = s_ff.cfg;
          endcase
        end
      end
    end

    // Emergency stop latches until software drops the run bit
    if (s_ff.syncB.estop) begin
      nxt_s.estopHeld = 1'b1;
    end else if (!s_ff.ctrl.run) begin
      nxt_s.estopHeld = 1'b0;
    end

    running = s_ff.ctrl.run && !s_ff.estopHeld;
    wantRev = s_ff.ctrl.dir && s_ff.cfg.revEn;
    lim = fMin(s_ff.cfg.lowLim, s_ff.cfg.maxF);
    goal = fMin(s_ff.target, s_ff.cfg.maxF);
    if (goal < lim) begin
      goal = lim;
    end
    // A direction change passes through zero first
    if (!running || wantRev != s_ff.drv.reverse) begin
      goal = '0;
    end

    if (s_ff.ctrl.jog) begin
      pairSel = JOG_SET;
    end else if (s_ff.ctrl.segMode) begin
      pairSel = s_ff.ctrl.seg;
    end else begin
      pairSel = s_ff.syncB.accelSel;
    end
    f = s_ff.drv.freq;
    tActive = (goal > f) ? s_ff.cfg.rampT[{pairSel, 1'b0}]
                         : s_ff.cfg.rampT[{pairSel, 1'b1}];
    if (s_ff.estopHeld) begin
      tActive = s_ff.cfg.emergT;
    end
    span = timeCycles(tActive);

    if (s_ff.estopHeld && s_ff.cfg.emergT == '0) begin
      nxt_s.drv.freq = '0;
      nxt_s.drv.outEn = 1'b0;
      nxt_s.acc = '0;
    end else if (running && f < lim && goal >= lim
                 && wantRev == s_ff.drv.reverse) begin
      nxt_s.drv.freq = lim;
      nxt_s.drv.outEn = 1'b1;
      nxt_s.acc = '0;
    end else if (f == goal) begin
      nxt_s.acc = '0;
      if (f == '0) begin
        nxt_s.drv.reverse = wantRev;
        nxt_s.drv.outEn = running;
      end
    end else begin
      // Rate maxF per span cycles, one 0.01 Hz step at a time
      nxt_s.drv.outEn = 1'b1;
      nxt_s.acc = s_ff.acc + 40'(s_ff.cfg.maxF);
      if (nxt_s.acc >= span) begin
        nxt_s.acc = nxt_s.acc - span;
        nxt_s.drv.freq = (goal > f) ? f + FW'(1) : f - FW'(1);
      end
    end

    // Voltage curve: iterative divide, new result every DIVW+2 cycles
    effMax = s_ff.cfg.maxV;
    effBoost = vMin(s_ff.cfg.boost, effMax);
    effMid = vMin(s_ff.cfg.midV, effMax);
    if (effMid < effBoost) begin
      effMid = effBoost;
    end
    unique case (s_ff.dst)
      DIV_IDLE: begin
        nxt_s.dst = DIV_RUN;
        nxt_s.divCnt = 5'(DIVW);
        nxt_s.rem = '0;
        nxt_s.quo = '0;
        f = fMin(s_ff.drv.freq, s_ff.cfg.maxF);
        if (f <= s_ff.cfg.minF) begin
          nxt_s.base = effBoost;
          nxt_s.num = '0;
          nxt_s.den = FW'(1);
        end else if (f <= s_ff.cfg.midF) begin
          nxt_s.base = effBoost;
          nxt_s.num = DIVW'(effMid - effBoost) * DIVW'(f - s_ff.cfg.minF);
          nxt_s.den = s_ff.cfg.midF - s_ff.cfg.minF;
        end else begin
          nxt_s.base = effMid;
          nxt_s.num = DIVW'(effMax - effMid) * DIVW'(f - s_ff.cfg.midF);
          nxt_s.den = (s_ff.cfg.maxF > s_ff.cfg.midF)
                      ? s_ff.cfg.maxF - s_ff.cfg.midF : FW'(1);
        end
      end
      DIV_RUN: begin
        if (s_ff.divCnt == '0) begin
          nxt_s.dst = DIV_IDLE;
          nxt_s.drv.volt = vMin(s_ff.base + s_ff.quo[VW-1:0], effMax);
        end else begin
          r = {s_ff.rem[FW-1:0], s_ff.num[DIVW-1]};
          nxt_s.num = {s_ff.num[DIVW-2:0], 1'b0};
          nxt_s.divCnt = s_ff.divCnt - 5'(1);
          if (r >= {1'b0, s_ff.den}) begin
            nxt_s.rem = r - {1'b0, s_ff.den};
            nxt_s.quo = {s_ff.quo[DIVW-2:0], 1'b1};
          end else begin
            nxt_s.rem = r;
            nxt_s.quo = {s_ff.quo[DIVW-2:0], 1'b0};
          end
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff <= '{cfg: CFG_DEFAULT, drv: '{volt: DEF_BOOST, default: '0},
                dst: DIV_IDLE, den: 17'h00001, default: '0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign pready  = s_ff.pready;
  assign prdata  = s_ff.prdata;
  assign pslverr = s_ff.pslverr;
  assign drive   = s_ff.drv;
endmodule : vf_curve_and_ramp_control

// ===== dv/terminal_model.sv
`timescale 1ns/1ps
module terminal_model (
  input  wire logic                    mclk,
  input  wire logic                    stopReq,
  input  wire logic [1:0]              selReq,
  output vf_ramp_pkg::terminals_t      terminals
);
  import vf_ramp_pkg::*;
  // Switch contacts, seen one edge after the request
  always @(posedge mclk) begin
    terminals.estop    <= stopReq;
    terminals.accelSel <= selReq;
  end
endmodule : terminal_model

// ===== dv/vf_ramp_monitor.sv
`timescale 1ns/1ps
module vf_ramp_monitor (
  input wire logic                    mclk,
  input wire logic                    rst_n,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic [7:0]              paddr,
  input wire logic                    pready,
  input wire logic                    pslverr,
  input wire vf_ramp_pkg::drive_t     drive
);
  import vf_ramp_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  freq_step_a: assert property (
    drive.outEn && $past(drive.outEn) |-> drive.freq <= $past(drive.freq) + 1
    && drive.freq + 1 >= $past(drive.freq)) else $error("ramp jumped");
  dir_flip_a: assert property (
    $changed(drive.reverse) |-> $past(drive.freq) == 0)
    else $error("direction flipped while turning");
  idle_zero_a: assert property (
    !drive.outEn |-> drive.freq == 0) else $error("freq without output");
  freq_top_a: assert property (
    drive.freq <= MAXF_HI) else $error("freq above top");
  ready_pulse_a: assert property (
    pready |=> !pready) else $error("ready too long");
  ready_wait_a: assert property (
    psel && penable && !pready |=> pready) else $error("ready late");
  ready_cause_a: assert property (
    pready |-> psel && penable) else $error("ready without access");
  err_map_a: assert property (
    pready |-> pslverr == (paddr > OFS_VOLT || paddr[1:0] != 2'h0))
    else $error("error flag wrong");
endmodule : vf_ramp_monitor
bind vf_curve_and_ramp_control vf_ramp_monitor mon (
  .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .paddr(paddr), .pready(pready), .pslverr(pslverr), .drive(drive));

// ===== dv/tb.sv
`timescale 1ns/1ps
module tb;
  import vf_ramp_pkg::*;
  logic       mclk, rst_n, psel, penable, pwrite, pready, pslverr, ev;
  logic       stopReq;
  logic [1:0] selReq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rv, prev;
  terminals_t terminals;
  drive_t     drive;
  int         miscompares, total_checks, cyc;

  vf_curve_and_ramp_control #(.TENTH_CYCLES(10)) dut (
    .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .terminals(terminals),
    .drive(drive));
  terminal_model part (.mclk(mclk), .stopReq(stopReq), .selReq(selReq),
    .terminals(terminals));

  initial begin
    mclk = 0;
    forever #20 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      end_of_test();
    end
  end

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge mclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    do @(posedge mclk); while (pready !== 1'b1);
    rv = prdata;
    ev = pslverr;
    psel <= 0; penable <= 0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    apb(0, a, 32'h0);
  endtask : rd

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic rng(input string n, input int lo, input int hi);
    total_checks++;
    if (^rv === 1'bx || rv < lo || rv > hi) begin
      miscompares++;
      $display("MISMATCH %s expected %0d..%0d seen %h", n, lo, hi, rv);
    end
  endtask : rng

  task automatic t_defaults;
    logic [7:0] a[5] = '{OFS_MAXF, OFS_LOWLIM, OFS_REVEN, OFS_EMERG, OFS_RAMP0};
    logic [31:0] x[5] = '{32'(DEF_MAXF), 32'(DEF_LOWLIM), 32'h1,
                          32'(DEF_EMERG), 32'(DEF_RAMP)};
    foreach (a[i]) begin
      rd(a[i]);
      chk("default", x[i], rv);
    end
    rd(OFS_VOLT);
    chk("boost volt", 32'(DEF_BOOST), rv & 32'h1FFF);
    rd(8'hFC);
    chk("unmapped", 32'h1, 32'(ev));
  endtask : t_defaults

  task automatic t_lock;
    wr(OFS_LOWLIM, 32'h64);
    wr(OFS_LOCK, 32'h1);
    wr(OFS_MAXF, 32'h7D0);
    wr(OFS_RESTOR, 32'(RESTOR_CMD));
    rd(OFS_MAXF);
    chk("locked write", 32'(DEF_MAXF), rv);
    rd(OFS_LOWLIM);
    chk("locked restore", 32'h64, rv);
    wr(OFS_LOCK, 32'h0);
    wr(OFS_RESTOR, 32'(RESTOR_CMD));
    rd(OFS_LOWLIM);
    chk("restore", 32'(DEF_LOWLIM), rv);
    wr(OFS_LOWLIM, 32'(DEF_MAXF));
    rd(OFS_LOWLIM);
    chk("limit order", 32'(DEF_LOWLIM), rv);
  endtask : t_lock

  // Pair one at half rate, pair two at full rate
  task automatic t_ramp;
    wr(OFS_MAXF, 32'h3E8);
    wr(OFS_RAMP0, 32'hC8);
    wr(OFS_TARGET, 32'h3E8);
    wr(OFS_CTRL, 32'h20);
    repeat (1000) @(posedge mclk);
    rd(OFS_FREQ);
    rng("pair one ramp", 495, 515);
    prev = rv;
    selReq <= 2'h1;
    repeat (200) @(posedge mclk);
    rd(OFS_FREQ);
    rv = rv - prev;
    rng("pair two ramp", 195, 215);
  endtask : t_ramp

  task automatic t_reverse;
    wr(OFS_REVEN, 32'h0);
    wr(OFS_CTRL, 32'h30);
    // Long enough that a wrongly honoured reverse would have flipped
    repeat (800) @(posedge mclk);
    chk("no reverse", 32'h0, 32'(drive.reverse));
    wr(OFS_REVEN, 32'h1);
    // Full ramp down from maximum at pair two takes 1000 cycles
    repeat (1100) @(posedge mclk);
    chk("reverse", 32'h1, 32'(drive.reverse));
  endtask : t_reverse

  task automatic t_estop;
    stopReq <= 1;
    repeat (6) @(posedge mclk);
    chk("coast out", 32'h0, 32'(drive.outEn));
    chk("coast freq", 32'h0, 32'(drive.freq));
    stopReq <= 0;
    wr(OFS_CTRL, 32'h0);
  endtask : t_estop

  task automatic t_curve;
    wr(OFS_MAXV, 32'h32);
    repeat (70) @(posedge mclk);
    chk("boost clamp", 32'h32, 32'(drive.volt));
    wr(OFS_MAXV, 32'(DEF_MAXV));
    wr(OFS_TARGET, 32'(DEF_MIDF));
    wr(OFS_CTRL, 32'h20);
    repeat (600) @(posedge mclk);
    chk("mid volt", 32'(DEF_MIDV), 32'(drive.volt));
    wr(OFS_MAXV, 32'h96);
    repeat (70) @(posedge mclk);
    chk("mid clamp", 32'h96, 32'(drive.volt));
  endtask : t_curve

  // Start at the lower limit, then pair four, pair three, emergency ramp
  task automatic t_pairs;
    wr(OFS_CTRL, 32'h0);
    repeat (550) @(posedge mclk);
    wr(OFS_LOWLIM, 32'h258);
    wr(OFS_CTRL, 32'h20);
    repeat (10) @(posedge mclk);
    chk("low limit", 32'h258, 32'(drive.freq));
    wr(8'h44, 32'h190);
    wr(8'h3C, 32'hC8);
    wr(OFS_CTRL, 32'h28);
    wr(OFS_TARGET, 32'h0);
    wr(OFS_LOWLIM, 32'h0);
    rd(OFS_FREQ);
    prev = rv;
    repeat (200) @(posedge mclk);
    rd(OFS_FREQ);
    rv = prev - rv;
    rng("jog ramp", 46, 58);
    wr(OFS_CTRL, 32'h26);
    rd(OFS_FREQ);
    prev = rv;
    repeat (200) @(posedge mclk);
    rd(OFS_FREQ);
    rv = prev - rv;
    rng("segment ramp", 96, 110);
    wr(OFS_EMERG, 32'h64);
    stopReq <= 1;
    repeat (20) @(posedge mclk);
    chk("estop ramp", 32'h1, 32'(drive.outEn));
    repeat (500) @(posedge mclk);
    chk("estop end", 32'h0, 32'(drive.freq));
    stopReq <= 0;
    wr(OFS_CTRL, 32'h0);
  endtask : t_pairs

  task automatic end_of_test;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test

  initial begin
    rst_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0;
    pwdata = '0; stopReq = 0; selReq = '0;
    repeat (20) @(posedge mclk);
    rst_n <= 1;
    t_defaults();
    t_lock();
    t_ramp();
    t_reverse();
    t_estop();
    t_curve();
    t_pairs();
    end_of_test();
  end
endmodule : tb
